/* hw/liu_regs_pkg.sv */
// package: register map, field layout, reset values and shared types of the register slice
package liu_regs_pkg;

   // ==========================================================
   // register offsets (byte addresses are four times the index)
   localparam logic [7:0] idx_tx_output_disable         = 8'h12;
   localparam logic [7:0] idx_alarm_signal_state        = 8'h13;
   localparam logic [7:0] idx_alarm_signal_irq_mask     = 8'h14;
   localparam logic [7:0] idx_alarm_signal_change_flags = 8'h15;
   localparam logic [7:0] idx_waveform_broadcast_select = 8'h16;
   localparam logic [7:0] idx_waveform_sample_pointer   = 8'h17;
   localparam logic [7:0] idx_waveform_sample_value     = 8'h18;

   // ==========================================================
   // field layout
   localparam int chan_sel_lsb    = 5;
   localparam int chan_sel_width  = 3;
   localparam int slot_sel_width  = 5;
   localparam int sample_width    = 7;
   localparam int reg_width       = 8;

   // ==========================================================
   // reset values
   localparam logic [7:0] reg_reset_value    = 8'h00;
   localparam logic [6:0] sample_reset_value = 7'h00;

   // sample pointer split into channel and slot
   typedef struct packed
   {
      logic [2:0] sample_channel_select;
      logic [4:0] sample_slot_select;
   } sample_pointer_type;

   // avalon request carried as one bundle
   typedef struct packed
   {
      logic       read;
      logic       write;
      logic [7:0] index;
      logic [7:0] wdata;
   } bus_request_type;

   // bus slave phases
   typedef enum logic [1:0] {bus_idle, bus_answer, bus_release} bus_state_type;

endpackage

/* hw/liu_alarm_waveform_regs.sv */
// module: control and status register slice of an eight-channel line interface
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps

module liu_alarm_waveform_regs #(
   parameter int num_channels = 8,
   parameter int num_slots    = 32
) (
   input  wire logic                    clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    por_n_i,
   input  wire logic                    soft_reset_i,
   input  wire logic [num_channels-1:0] alarm_detect_i,
   input  wire logic [9:0]              avs_address_i,
   input  wire logic                    avs_read_i,
   input  wire logic                    avs_write_i,
   input  wire logic [31:0]             avs_writedata_i,
   output logic      [31:0]             avs_readdata_o,
   output logic                         avs_waitrequest_o,
   output logic      [num_channels-1:0] tx_hiz_select_o,
   output logic      [num_channels-1:0] tx_drive_en_o,
   output logic                         irq_o,
   output logic                         irq_n_o
);

   // ==========================================================
   // overview
   // seven byte-wide registers sit at word indices 0x12 to 0x18
   // the byte address on the bus is four times the word index
   // only bits [7:0] of the write data are used; upper read bits are zero
   // unmapped indices read as zero and ignore writes
   //
   // ==========================================================
   // bus timing
   // a request is taken on the edge where the slave is idle and read or write is high
   // waitrequest drops for exactly one cycle after the take edge
   // the master samples waitrequest low on the next edge, the answer edge
   // writes take effect on the answer edge, where the master ends the transfer
   // read data is captured on the take edge and stands through the answer edge
   // one dead cycle with waitrequest high follows every answer
   // the dead cycle keeps a request still held from being taken twice
   // a back-to-back master is taken again two edges after the answer edge
   // waitrequest stays high for as long as device reset is low
   //
   // ==========================================================
   // resets
   // device reset clears control, status, change flags and the bus slave
   // software reset clears control, status and change flags only
   // neither of them touches the sample memory, which keeps its contents
   // power-up reset clears every sample slot and nothing else
   // at power-up device reset and power-up reset are expected low together
   // all resets are synchronous and sampled on the rising clock edge
   // after reset every channel driver is enabled and the interrupt is low
   //
   // ==========================================================
   // alarm path
   // each alarm input comes from the receive side, outside this clock domain
   // two flip-flops retime it before any other logic looks at it
   // the status register copies the retimed value once per clock
   // a change is a difference between the retimed value and the status
   // so a change flag sets on the same edge that the status bit moves
   // the mask gates only the change flag; the status bit always stays live
   // masked changes are dropped, not held back for a later unmask
   // pulses shorter than one clock period may be missed entirely
   //
   // ==========================================================
   // interrupt
   // the interrupt is high while any change flag is set
   // both pin polarities come straight from flip-flops and always agree
   // reading the change-flag register clears all flags on the take edge
   // the value read is the set of flags just before the clear
   // a change on the same edge as the clear sets its flag again: set wins
   // so no change is lost between the read and the clear
   // writes to the change-flag and status registers have no effect
   //
   // ==========================================================
   // waveform samples
   // the pointer register splits into a channel field and a slot field
   // the channel field sits in bits [7:5] and the slot field in bits [4:0]
   // every channel owns num_slots slots of seven-bit two's complement samples
   // slots past the ones used by the current line mode are still reachable
   // software must stay clear of them; no check is made here
   // a sample write goes to the pointed channel when no broadcast bit is set
   // any broadcast bit set sends the write to all selected channels at once
   // the slot always comes from the pointer, also for broadcast writes
   // the pointed channel field is ignored while broadcast is active
   // bit 7 of the sample value is reserved and dropped on write
   // it reads back as zero whatever software wrote there
   // reads always come from the pointed channel, even with broadcast set
   // the pointer does not advance after an access
   //
   // ==========================================================
   // outputs
   // a set output-disable bit puts the matching driver in high impedance
   // the drive enable output is the inverse of the high impedance select
   // both change on the same edge as the output-disable register
   // every output of this module comes from a register

   // ==========================================================
   // state declarations
   liu_regs_pkg::bus_state_type      bus_state;
   liu_regs_pkg::bus_state_type      next_bus_state;
   liu_regs_pkg::bus_request_type    req;
   liu_regs_pkg::sample_pointer_type sample_pointer;
   liu_regs_pkg::sample_pointer_type next_sample_pointer;
   logic [num_channels-1:0] tx_output_disable;
   logic [num_channels-1:0] next_tx_output_disable;
   logic [num_channels-1:0] alarm_sync1;
   logic [num_channels-1:0] alarm_sync2;
   logic [num_channels-1:0] alarm_signal_state;
   logic [num_channels-1:0] next_alarm_signal_state;
   logic [num_channels-1:0] alarm_signal_irq_mask;
   logic [num_channels-1:0] next_alarm_signal_irq_mask;
   logic [num_channels-1:0] alarm_change_flag;
   logic [num_channels-1:0] next_alarm_change_flag;
   logic [num_channels-1:0] broadcast_channel_select;
   logic [num_channels-1:0] next_broadcast_channel_select;
   logic [num_channels-1:0] sample_write_en;
   logic [31:0]             readdata;
   logic [31:0]             next_readdata;
   logic                    next_irq;
   logic                    soft_clear;
   logic                    do_write;
   logic                    do_read;
   logic [6:0]              read_sample;
   logic [liu_regs_pkg::sample_width-1:0] sample_mem [num_channels][num_slots];

   // request decode, word index taken from byte address
   always_comb
   begin
      req.read  = avs_read_i;
      req.write = avs_write_i;
      req.index = avs_address_i[9:2];
      req.wdata = avs_writedata_i[7:0];
   end

   // soft or device reset clears control, status and change flags, not the sample memory
   assign soft_clear = !rstn_i || soft_reset_i;
   // writes land on the answer edge, where the master sees waitrequest low
   assign do_write   = (bus_state == liu_regs_pkg::bus_answer) && req.write;
   assign do_read    = (bus_state == liu_regs_pkg::bus_idle) && req.read;

   // ==========================================================
   // bus slave: take in idle, answer next cycle, one release cycle
   always_comb
   begin
      next_bus_state = bus_state;
      unique case (bus_state)
         liu_regs_pkg::bus_idle:
         begin
            if (req.read || req.write)
            begin
               next_bus_state = liu_regs_pkg::bus_answer;
            end
         end
         liu_regs_pkg::bus_answer:  next_bus_state = liu_regs_pkg::bus_release;
         liu_regs_pkg::bus_release: next_bus_state = liu_regs_pkg::bus_idle;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         bus_state         <= liu_regs_pkg::bus_idle;
         avs_waitrequest_o <= 1'b1;
      end
      else
      begin
         bus_state         <= next_bus_state;
         avs_waitrequest_o <= !(next_bus_state == liu_regs_pkg::bus_answer);
      end
   end

   // ==========================================================
   // alarm input synchroniser
   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         alarm_sync1 <= '0;
         alarm_sync2 <= '0;
      end
      else
      begin
         alarm_sync1 <= alarm_detect_i;
         alarm_sync2 <= alarm_sync1;
      end
   end

   // ==========================================================
   // control registers, status, change flags, interrupt
   always_comb
   begin
      next_tx_output_disable        = tx_output_disable;
      next_alarm_signal_irq_mask    = alarm_signal_irq_mask;
      next_broadcast_channel_select = broadcast_channel_select;
      next_sample_pointer           = sample_pointer;
      next_alarm_signal_state       = alarm_sync2;
      next_alarm_change_flag        = alarm_change_flag;
      if (do_read && req.index == liu_regs_pkg::idx_alarm_signal_change_flags)
      begin
         next_alarm_change_flag = '0;
      end
      // set wins over the read clear
      next_alarm_change_flag = next_alarm_change_flag
         | ((alarm_sync2 ^ alarm_signal_state) & alarm_signal_irq_mask);
      if (do_write)
      begin
         unique case (req.index)
            liu_regs_pkg::idx_tx_output_disable:
               next_tx_output_disable = req.wdata[num_channels-1:0];
            liu_regs_pkg::idx_alarm_signal_irq_mask:
               next_alarm_signal_irq_mask = req.wdata[num_channels-1:0];
            liu_regs_pkg::idx_waveform_broadcast_select:
               next_broadcast_channel_select = req.wdata[num_channels-1:0];
            liu_regs_pkg::idx_waveform_sample_pointer:
               next_sample_pointer = req.wdata;
            default:
               next_sample_pointer = sample_pointer;
         endcase
      end
      next_irq = |next_alarm_change_flag;
   end

   always_ff @(posedge clk_i)
   begin
      if (soft_clear)
      begin
         tx_output_disable        <= liu_regs_pkg::reg_reset_value;
         alarm_signal_state       <= liu_regs_pkg::reg_reset_value;
         alarm_signal_irq_mask    <= liu_regs_pkg::reg_reset_value;
         alarm_change_flag        <= liu_regs_pkg::reg_reset_value;
         broadcast_channel_select <= liu_regs_pkg::reg_reset_value;
         sample_pointer           <= liu_regs_pkg::reg_reset_value;
         tx_hiz_select_o          <= liu_regs_pkg::reg_reset_value;
         tx_drive_en_o            <= '1;
         irq_o                    <= 1'b0;
         irq_n_o                  <= 1'b1;
      end
      else
      begin
         tx_output_disable        <= next_tx_output_disable;
         alarm_signal_state       <= next_alarm_signal_state;
         alarm_signal_irq_mask    <= next_alarm_signal_irq_mask;
         alarm_change_flag        <= next_alarm_change_flag;
         broadcast_channel_select <= next_broadcast_channel_select;
         sample_pointer           <= next_sample_pointer;
         tx_hiz_select_o          <= next_tx_output_disable;
         tx_drive_en_o            <= ~next_tx_output_disable;
         irq_o                    <= next_irq;
         irq_n_o                  <= !next_irq;
      end
   end

   // ==========================================================
   // waveform sample memory, cleared only at power-up
   always_comb
   begin
      sample_write_en = '0;
      if (do_write && req.index == liu_regs_pkg::idx_waveform_sample_value)
      begin
         if (|broadcast_channel_select)
         begin
            sample_write_en = broadcast_channel_select;
         end
         else
         begin
            sample_write_en[sample_pointer.sample_channel_select] = 1'b1;
         end
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < num_channels; ch++)
      begin : g_channel
         always_ff @(posedge clk_i)
         begin
            if (!por_n_i)
            begin
               for (int s = 0; s < num_slots; s++)
               begin
                  sample_mem[ch][s] <= liu_regs_pkg::sample_reset_value;
               end
            end
            else if (sample_write_en[ch])
            begin
               // seven-bit two's complement stored as is; bit 7 dropped
               sample_mem[ch][sample_pointer.sample_slot_select] <=
                  req.wdata[liu_regs_pkg::sample_width-1:0];
            end
         end
      end
   endgenerate

   // ==========================================================
   // read data, latched when the request is taken
   assign read_sample =
      sample_mem[sample_pointer.sample_channel_select][sample_pointer.sample_slot_select];

   always_comb
   begin
      next_readdata = readdata;
      if (do_read)
      begin
         next_readdata = '0;
         unique case (req.index)
            liu_regs_pkg::idx_tx_output_disable:
               next_readdata[7:0] = tx_output_disable;
            liu_regs_pkg::idx_alarm_signal_state:
               next_readdata[7:0] = alarm_signal_state;
            liu_regs_pkg::idx_alarm_signal_irq_mask:
               next_readdata[7:0] = alarm_signal_irq_mask;
            liu_regs_pkg::idx_alarm_signal_change_flags:
               next_readdata[7:0] = alarm_change_flag;
            liu_regs_pkg::idx_waveform_broadcast_select:
               next_readdata[7:0] = broadcast_channel_select;
            liu_regs_pkg::idx_waveform_sample_pointer:
               next_readdata[7:0] = sample_pointer;
            liu_regs_pkg::idx_waveform_sample_value:
               next_readdata[7:0] = {1'b0, read_sample};
            default:
               next_readdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
      begin
         readdata <= '0;
      end
      else
      begin
         readdata <= next_readdata;
      end
   end

   assign avs_readdata_o = readdata;

endmodule // liu_alarm_waveform_regs

/* testbench/liu_regs_properties.sv */
// checker: port properties of the alarm and waveform register slice
`timescale 1ns/1ps
module liu_regs_properties #(
   parameter int num_channels = 8,
   parameter int num_slots    = 32
) (
   input wire logic                    clk_i,
   input wire logic                    rstn_i,
   input wire logic [num_channels-1:0] alarm_detect_i,
   input wire logic [9:0]              avs_address_i,
   input wire logic                    avs_read_i,
   input wire logic                    avs_write_i,
   input wire logic [31:0]             avs_writedata_i,
   input wire logic                    avs_waitrequest_o,
   input wire logic [num_channels-1:0] tx_hiz_select_o,
   input wire logic [num_channels-1:0] tx_drive_en_o,
   input wire logic                    irq_o,
   input wire logic                    irq_n_o
);
   logic [num_channels-1:0] last_alarm;
   logic [3:0]              calm;
   logic [3:0]              next_calm;
   // cycles since the alarm inputs last moved, saturating
   always_comb
   begin
      next_calm = (alarm_detect_i != last_alarm) ? 4'h0 : calm + {3'h0, calm != 4'hf};
   end
   always_ff @(posedge clk_i)
   begin
      last_alarm <= alarm_detect_i;
      calm       <= rstn_i ? next_calm : 4'h0;
   end
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // answer cycles of a flag read and of an output-disable write
   sequence flag_read_s;
      !avs_waitrequest_o && avs_read_i
         && avs_address_i[9:2] == liu_regs_pkg::idx_alarm_signal_change_flags;
   endsequence
   sequence hiz_write_s;
      !avs_waitrequest_o && avs_write_i
         && avs_address_i[9:2] == liu_regs_pkg::idx_tx_output_disable;
   endsequence
   drive_inverse_a: assert property (tx_drive_en_o == ~tx_hiz_select_o)
      else $error("drive enable not inverse of hi-z");
   hiz_follows_a: assert property (hiz_write_s |=>
      tx_hiz_select_o == $past(avs_writedata_i[num_channels-1:0])) else $error("hi-z stale");
   reset_clear_a: assert property ($rose(rstn_i) |-> tx_hiz_select_o == '0 && !irq_o)
      else $error("outputs not clear after reset");
   irq_cause_a: assert property ($rose(irq_o) |-> calm < 4'ha)
      else $error("interrupt without alarm change");
   flag_release_a: assert property (flag_read_s ##0 (calm > 4'h5) |=> !irq_o)
      else $error("flag read left interrupt up");
   irq_twin_a: assert property (irq_n_o == !irq_o)
      else $error("interrupt pins disagree");
   answer_time_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:2] !avs_waitrequest_o)
      else $error("bus answer late");
   answer_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("answer longer than one cycle");
endmodule // liu_regs_properties

/* testbench/host_bus_model.sv */
// host model: avalon-mm master that reaches the register slice
`timescale 1ns/1ps
module host_bus_model (
   input  wire logic        clk_i,
   input  wire logic        waitrequest_i,
   input  wire logic [31:0] readdata_i,
   output logic      [9:0]  address_o,
   output logic             read_o,
   output logic             write_o,
   output logic      [31:0] writedata_o
);
   // bus idle at time zero
   initial
   begin
      address_o   = 10'h3ff;
      read_o      = 1'b0;
      write_o     = 1'b0;
      writedata_o = 32'h0;
   end
   // one transfer: hold until waitrequest low, take data, then release
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
      @(posedge clk_i);
      address_o   <= {idx, 2'h0};
      writedata_o <= {24'h0, idx == liu_regs_pkg::idx_waveform_sample_value ? {1'b0, wd[6:0]} : wd};
      read_o      <= !wr;
      write_o     <= wr;
      do
         @(posedge clk_i);
      while (waitrequest_i);
      rd = readdata_i[7:0];
      read_o      <= 1'b0;
      write_o     <= 1'b0;
      address_o   <= ~{idx, 2'h0}; // released lines show no stale value
      writedata_o <= ~writedata_o;
   endtask
endmodule // host_bus_model

/* testbench/testbench.sv */
// testbench: self-checking run of the alarm and waveform register slice
`timescale 1ns/1ps
module testbench;
   localparam logic [7:0] r_hiz  = liu_regs_pkg::idx_tx_output_disable;
   localparam logic [7:0] r_st   = liu_regs_pkg::idx_alarm_signal_state;
   localparam logic [7:0] r_mask = liu_regs_pkg::idx_alarm_signal_irq_mask;
   localparam logic [7:0] r_flg  = liu_regs_pkg::idx_alarm_signal_change_flags;
   localparam logic [7:0] r_bc   = liu_regs_pkg::idx_waveform_broadcast_select;
   localparam logic [7:0] r_ptr  = liu_regs_pkg::idx_waveform_sample_pointer;
   localparam logic [7:0] r_val  = liu_regs_pkg::idx_waveform_sample_value;
   logic        clk_i, rstn_i, por_n_i, soft_reset_i, avs_read_i, avs_write_i;
   logic        avs_waitrequest_o, irq_o, irq_n_o;
   logic [7:0]  alarm_detect_i, tx_hiz_select_o, tx_drive_en_o, rd;
   logic [9:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o;
   int          fail_count, checked;
   liu_alarm_waveform_regs #(.num_channels(8), .num_slots(32)) DUT (
      .clk_i(clk_i), .rstn_i(rstn_i), .por_n_i(por_n_i), .soft_reset_i(soft_reset_i),
      .alarm_detect_i(alarm_detect_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .tx_hiz_select_o(tx_hiz_select_o), .tx_drive_en_o(tx_drive_en_o),
      .irq_o(irq_o), .irq_n_o(irq_n_o));
   host_bus_model host (.clk_i(clk_i), .waitrequest_i(avs_waitrequest_o),
      .readdata_i(avs_readdata_o), .address_o(avs_address_i), .read_o(avs_read_i),
      .write_o(avs_write_i), .writedata_o(avs_writedata_i));
   // ==========
   // helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host.xfer(1'b1, idx, d, rd);
   endtask
   task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] exp);
      host.xfer(1'b0, idx, 8'h00, rd);
      check(what, rd, exp);
   endtask
   // ==========
   // scenarios
   // reset values, one unmapped index, pins after reset
   task automatic t_reset;
      for (int i = 18; i < 26; i++)
         rc("reset value", 8'(i), 8'h00);
      check("hiz pins", tx_hiz_select_o, 8'h00);
   endtask
   // output disable drives the pins and reads back
   task automatic t_hiz;
      wr(r_hiz, 8'ha5);
      @(posedge clk_i);
      check("hiz pins", tx_hiz_select_o, 8'ha5);
      check("drive pins", tx_drive_en_o, 8'h5a);
      rc("hiz readback", r_hiz, 8'ha5);
   endtask
   // alarm status, masked latching, flag clear on read
   task automatic t_alarm;
      wr(r_mask, 8'h0f);
      alarm_detect_i <= 8'h81;
      repeat (8) @(posedge clk_i);
      check("irq raised", {7'h0, irq_o}, 8'h01);
      rc("alarm state", r_st, 8'h81);
      wr(r_st, 8'hff);
      rc("state after write", r_st, 8'h81);
      rc("change flags", r_flg, 8'h01);
      @(posedge clk_i);
      check("irq released", {7'h0, irq_n_o}, 8'h01);
      rc("flags cleared", r_flg, 8'h00);
      wr(r_mask, 8'h00);
      alarm_detect_i <= 8'h00;
      repeat (8) @(posedge clk_i);
      check("masked irq", {7'h0, irq_o}, 8'h00);
      rc("live state", r_st, 8'h00);
      rc("masked flags", r_flg, 8'h00);
   endtask
   // pointed and broadcast sample writes, soft and power-up reset
   task automatic t_wave;
      wr(r_ptr, 8'h57);
      wr(r_val, 8'hbf);
      rc("pointed sample", r_val, 8'h3f);
      wr(r_ptr, 8'h77);
      rc("other channel", r_val, 8'h00);
      wr(r_bc, 8'h30);
      wr(r_ptr, 8'h00);
      wr(r_val, 8'h40);
      wr(r_bc, 8'h00);
      for (int c = 0; c < 8; c++)
      begin
         wr(r_ptr, {c[2:0], 5'h00});
         rc("broadcast copy", r_val, (c == 4 || c == 5) ? 8'h40 : 8'h00);
      end
      soft_reset_i <= 1'b1;
      @(posedge clk_i);
      soft_reset_i <= 1'b0;
      rc("hiz after soft reset", r_hiz, 8'h00);
      wr(r_ptr, 8'h57);
      rc("sample after soft reset", r_val, 8'h3f);
      por_n_i <= 1'b0;
      @(posedge clk_i);
      por_n_i <= 1'b1;
      rc("sample after power-up", r_val, 8'h00);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // 10 MHz clock
   initial
   begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // reset for 16 cycles, then the scenarios
   initial
   begin
      rstn_i = 1'b0;
      por_n_i = 1'b0;
      soft_reset_i = 1'b0;
      alarm_detect_i = 8'h00;
      fail_count = 0;
      checked = 0;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      por_n_i <= 1'b1;
      t_reset;
      t_hiz;
      t_alarm;
      t_wave;
      final_report;
   end
   // watchdog: the run needs well under 1000 cycles
   initial
   begin
      #2000000;
      fail_count++;
      final_report;
   end
endmodule // testbench
bind liu_alarm_waveform_regs liu_regs_properties #(
   .num_channels(num_channels), .num_slots(num_slots)) props (
   .clk_i(clk_i), .rstn_i(rstn_i), .alarm_detect_i(alarm_detect_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_waitrequest_o(avs_waitrequest_o),
   .tx_hiz_select_o(tx_hiz_select_o), .tx_drive_en_o(tx_drive_en_o),
   .irq_o(irq_o), .irq_n_o(irq_n_o));
